/* File: design/dual_source_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "dual_source_select_map.vh"

module dual_source_select #(
  parameter FW          = 16,
  parameter EXTENDED_IO = 1
) (
  // Clock, reset and enable.
  input  wire          pclk,
  input  wire          presetn,
  input  wire          ce,
  // APB slave.
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output reg           pslverr,
  // Terminal and keypad pins.
  input  wire [4:0]    multi_function_inputs,
  input  wire          forward_run_input,
  input  wire          reverse_run_input,
  input  wire          key_run,
  input  wire          key_stop,
  // Serial link command and reference.
  input  wire          serial_run,
  input  wire          serial_reverse,
  input  wire [FW-1:0] serial_ref,
  // Analog and stepped references.
  input  wire [FW-1:0] pot_ref,
  input  wire [FW-1:0] voltage_analog_input,
  input  wire [FW-1:0] dual_analog_input_ma,
  input  wire [FW-1:0] dual_analog_input_volt,
  input  wire [FW-1:0] updown_ref,
  // Drive outputs.
  output reg  [FW-1:0] out_freq_q,
  output reg           out_reverse_q,
  output reg           running_q,
  output reg           alt_set_q
);

  reg  [1:0]          cmd_src1_q;
  reg  [3:0]          frq_src1_q;
  reg  [1:0]          alt_cmd_source_select_q;
  reg  [3:0]          alt_freq_source_select_q;
  reg  [5*5-1:0]      input_function_codes_q;
  reg  [15:0]         accel_q;
  reg  [15:0]         decel_q;
  reg  [FW-1:0]       keypad1_q;
  reg  [FW-1:0]       keypad2_q;
  reg  [8:0]          sync1_q;
  reg  [8:0]          sync2_q;
  reg                 key_run_d1_q;
  reg                 key_stop_d1_q;
  reg                 kp_run_q;
  reg  [15:0]         step_cnt_q;
  wire [4:0]          sel_match;
  wire                alt_set_d;
  wire [1:0]          cmd_eff;
  wire [3:0]          frq_eff;
  wire                fwd_s;
  wire                rev_s;
  reg                 want_run;
  reg                 want_rev;
  reg  [FW-1:0]       ref_freq;
  reg  [FW-1:0]       target;
  wire                up;
  wire                down;
  wire [15:0]         period;
  wire                wr;
  wire                rd;
  reg                 wr_ok;
  reg                 addr_ok;
  wire [2:0]          func_idx;

  function [FW-1:0] sat_add;
    input [FW-1:0] a;
    input [FW-1:0] b;
    reg   [FW:0]   s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[FW] ? {FW{1'b1}} : s[FW-1:0];
    end
  endfunction

  function cmd_ok;
    input [1:0] v;
    begin
      cmd_ok = (v != `CMD_SERIAL) || (EXTENDED_IO != 0);
    end
  endfunction

  function frq_ok;
    input [3:0] v;
    begin
      frq_ok = (v <= `FRQ_MAX) && ((EXTENDED_IO != 0) ||
               !(v == `FRQ_DUAL_I || v == `FRQ_DUAL_V || v == `FRQ_POT_DUAL_I ||
                 v == `FRQ_POT_DUAL_V || v == `FRQ_SERIAL));
    end
  endfunction

  // Pin inputs pass two flip-flops before use.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end
    else if (ce)
    begin
      sync1_q <= {key_stop, key_run, reverse_run_input, forward_run_input, multi_function_inputs};
      sync2_q <= sync1_q;
    end
  end

  assign fwd_s = sync2_q[5];
  assign rev_s = sync2_q[6];

  // Per-input match against the alternate-set function code; inputs four and five need the extended build.
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1)
    begin : g_sel
      assign sel_match[gi] = (gi < `NUM_STD_INPUTS || EXTENDED_IO != 0) && sync2_q[gi] &&
                             (input_function_codes_q[gi*5 +: 5] == `FUNC_ALT_SET);
    end
  endgenerate
  assign alt_set_d = |sel_match;

  // Active set register; the new set acts from the cycle after the change.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alt_set_q <= 1'b0;
    else if (ce)
      alt_set_q <= alt_set_d;
  end

  assign cmd_eff = alt_set_q ? alt_cmd_source_select_q : cmd_src1_q;
  assign frq_eff = alt_set_q ? alt_freq_source_select_q : frq_src1_q;

  // Keypad run latch follows the keys whatever set is active.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_run_d1_q  <= 1'b0;
      key_stop_d1_q <= 1'b0;
      kp_run_q      <= 1'b0;
    end
    else if (ce)
    begin
      key_run_d1_q  <= sync2_q[7];
      key_stop_d1_q <= sync2_q[8];
      // A stop press wins over a run press in the same cycle.
      if (sync2_q[8] && !key_stop_d1_q)
        kp_run_q <= 1'b0;
      else if (sync2_q[7] && !key_run_d1_q)
        kp_run_q <= 1'b1;
    end
  end

  // Effective run command of the active command source.
  always @*
  begin
    want_run = 1'b0;
    want_rev = 1'b0;
    case (cmd_eff)
      `CMD_KEYPAD: want_run = kp_run_q;
      `CMD_TERM_FR:
      begin
        want_run = fwd_s ^ rev_s;
        want_rev = rev_s && !fwd_s;
      end
      `CMD_TERM_RUNDIR:
      begin
        want_run = fwd_s;
        want_rev = rev_s;
      end
      `CMD_SERIAL:
      begin
        want_run = serial_run;
        want_rev = serial_reverse;
      end
      default: want_run = 1'b0;
    endcase
  end

  // Frequency reference of the active frequency source.
  always @*
  begin
    case (frq_eff)
      `FRQ_KEYPAD1:    ref_freq = keypad1_q;
      `FRQ_KEYPAD2:    ref_freq = keypad2_q;
      `FRQ_POT:        ref_freq = pot_ref;
      `FRQ_VOLT:       ref_freq = voltage_analog_input;
      `FRQ_DUAL_I:     ref_freq = dual_analog_input_ma;
      `FRQ_DUAL_V:     ref_freq = dual_analog_input_volt;
      `FRQ_POT_DUAL_I: ref_freq = sat_add(pot_ref, dual_analog_input_ma);
      `FRQ_POT_DUAL_V: ref_freq = sat_add(pot_ref, dual_analog_input_volt);
      `FRQ_POT_VOLT:   ref_freq = sat_add(pot_ref, voltage_analog_input);
      `FRQ_SERIAL:     ref_freq = serial_ref;
      `FRQ_UPDOWN:     ref_freq = updown_ref;
      default:         ref_freq = {FW{1'b0}};
    endcase
  end

  // Target is zero on stop or while a direction reversal passes through zero.
  always @*
  begin
    if (!want_run)
      target = {FW{1'b0}};
    else if (want_rev != out_reverse_q && out_freq_q != {FW{1'b0}})
      target = {FW{1'b0}};
    else
      target = ref_freq;
  end

  assign up     = out_freq_q < target;
  assign down   = out_freq_q > target;
  assign period = up ? accel_q : decel_q;

  // Ramp: one frequency step each period; the run state is not reset by a set change.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_freq_q    <= {FW{1'b0}};
      out_reverse_q <= 1'b0;
      running_q     <= 1'b0;
      step_cnt_q    <= 16'h0000;
    end
    else if (ce)
    begin
      if (out_freq_q == {FW{1'b0}} && want_run)
        out_reverse_q <= want_rev;
      running_q <= (out_freq_q != {FW{1'b0}}) || want_run;
      if (!up && !down)
        step_cnt_q <= 16'h0000;
      else if (step_cnt_q + 16'h0001 >= period)
      begin
        step_cnt_q <= 16'h0000;
        if (up)
          out_freq_q <= out_freq_q + {{(FW-1){1'b0}}, 1'b1};
        else
          out_freq_q <= out_freq_q - {{(FW-1){1'b0}}, 1'b1};
      end
      else
        step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  // APB slave: zero-wait while enabled; bad value or address gives pslverr.
  assign pready   = ce;
  assign wr       = psel && penable && pwrite && ce;
  assign rd       = psel && !penable && !pwrite && ce;
  assign func_idx = paddr[4:2] - 3'h4;

  always @*
  begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `OFS_OUT_FREQ);
    wr_ok   = 1'b1;
    case (paddr)
      `OFS_CMD_SRC1, `OFS_CMD_SRC2: wr_ok = cmd_ok(pwdata[1:0]);
      `OFS_FRQ_SRC1, `OFS_FRQ_SRC2: wr_ok = frq_ok(pwdata[3:0]);
      `OFS_STATUS, `OFS_OUT_FREQ:   wr_ok = 1'b0;
      default:
      begin
        if (paddr >= `OFS_FUNC0 && paddr <= `OFS_FUNC4)
          wr_ok = (pwdata[4:0] <= `FUNC_MAX) &&
                  (func_idx < `NUM_STD_INPUTS || EXTENDED_IO != 0);
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_src1_q               <= `RST_CMD_SRC;
      frq_src1_q               <= `RST_FRQ_SRC;
      alt_cmd_source_select_q  <= `RST_CMD_SRC;
      alt_freq_source_select_q <= `RST_FRQ_SRC;
      input_function_codes_q   <= {`RST_FUNC4, `RST_FUNC, `RST_FUNC, `RST_FUNC, `RST_FUNC};
      accel_q                  <= `RST_PERIOD;
      decel_q                  <= `RST_PERIOD;
      keypad1_q                <= `RST_KEYPAD;
      keypad2_q                <= `RST_KEYPAD;
      prdata                   <= 32'h00000000;
      pslverr                  <= 1'b0;
    end
    else if (ce)
    begin
      pslverr <= psel && !penable && !(addr_ok && (pwrite ? wr_ok : 1'b1));
      if (wr && addr_ok && wr_ok)
      begin
        case (paddr)
          `OFS_CMD_SRC1: cmd_src1_q <= pwdata[1:0];
          `OFS_FRQ_SRC1: frq_src1_q <= pwdata[3:0];
          `OFS_CMD_SRC2: alt_cmd_source_select_q <= pwdata[1:0];
          `OFS_FRQ_SRC2: alt_freq_source_select_q <= pwdata[3:0];
          `OFS_ACCEL:    accel_q <= pwdata[15:0];
          `OFS_DECEL:    decel_q <= pwdata[15:0];
          `OFS_KEYPAD1:  keypad1_q <= pwdata[FW-1:0];
          `OFS_KEYPAD2:  keypad2_q <= pwdata[FW-1:0];
          default:       input_function_codes_q[func_idx*5 +: 5] <= pwdata[4:0];
        endcase
      end
      if (rd)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `OFS_CMD_SRC1: prdata[1:0] <= cmd_src1_q;
          `OFS_FRQ_SRC1: prdata[3:0] <= frq_src1_q;
          `OFS_CMD_SRC2: prdata[1:0] <= alt_cmd_source_select_q;
          `OFS_FRQ_SRC2: prdata[3:0] <= alt_freq_source_select_q;
          `OFS_ACCEL:    prdata[15:0] <= accel_q;
          `OFS_DECEL:    prdata[15:0] <= decel_q;
          `OFS_KEYPAD1:  prdata[FW-1:0] <= keypad1_q;
          `OFS_KEYPAD2:  prdata[FW-1:0] <= keypad2_q;
          `OFS_STATUS:
          begin
            prdata[`ST_ALT_SET]             <= alt_set_q;
            prdata[`ST_RUNNING]             <= running_q;
            prdata[`ST_REVERSE]             <= out_reverse_q;
            prdata[`ST_CMD_LSB +: 2]        <= cmd_eff;
            prdata[`ST_FRQ_LSB +: 4]        <= frq_eff;
            prdata[`ST_WANT_RUN]            <= want_run;
          end
          `OFS_OUT_FREQ: prdata[FW-1:0] <= out_freq_q;
          default:
          begin
            if (addr_ok)
              prdata[4:0] <= input_function_codes_q[func_idx*5 +: 5];
          end
        endcase
      end
    end
  end

endmodule // dual_source_select

`default_nettype wire

/* File: design/dual_source_select_map.vh */
`ifndef DUAL_SOURCE_SELECT_MAP_VH
`define DUAL_SOURCE_SELECT_MAP_VH

// Register byte offsets.
`define OFS_CMD_SRC1      8'h00
`define OFS_FRQ_SRC1      8'h04
`define OFS_CMD_SRC2      8'h08
`define OFS_FRQ_SRC2      8'h0c
`define OFS_FUNC0         8'h10
`define OFS_FUNC4         8'h20
`define OFS_ACCEL         8'h24
`define OFS_DECEL         8'h28
`define OFS_KEYPAD1       8'h2c
`define OFS_KEYPAD2       8'h30
`define OFS_STATUS        8'h34
`define OFS_OUT_FREQ      8'h38

// Reset values.
`define RST_CMD_SRC       2'h1
`define RST_FRQ_SRC       4'h0
`define RST_FUNC          5'h00
`define RST_FUNC4         5'h04
`define RST_PERIOD        16'h0010
`define RST_KEYPAD        16'h0000

// Field encodings.
`define FUNC_ALT_SET      5'h16
`define FUNC_MAX          5'h1b
`define CMD_KEYPAD        2'h0
`define CMD_TERM_FR       2'h1
`define CMD_TERM_RUNDIR   2'h2
`define CMD_SERIAL        2'h3
`define FRQ_KEYPAD1       4'h0
`define FRQ_KEYPAD2       4'h1
`define FRQ_POT           4'h2
`define FRQ_VOLT          4'h3
`define FRQ_DUAL_I        4'h4
`define FRQ_DUAL_V        4'h5
`define FRQ_POT_DUAL_I    4'h6
`define FRQ_POT_DUAL_V    4'h7
`define FRQ_POT_VOLT      4'h8
`define FRQ_SERIAL        4'h9
`define FRQ_UPDOWN        4'ha
`define FRQ_MAX           4'ha

// Status bit positions.
`define ST_ALT_SET        0
`define ST_RUNNING        1
`define ST_REVERSE        2
`define ST_CMD_LSB        4
`define ST_FRQ_LSB        8
`define ST_WANT_RUN       12

// Number of multi-function inputs and of standard-build inputs.
`define NUM_INPUTS        5
`define NUM_STD_INPUTS    3

`endif

/* File: sim/drive_terminals.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_terminals #(
  parameter int FW = 16
) (
  // Clock that times every level change.
  input  wire logic         pclk,
  // Command levels.
  output var logic [4:0]    multi_function_inputs,
  output var logic          forward_run_input,
  output var logic          reverse_run_input,
  output var logic          key_run,
  output var logic          key_stop,
  output var logic          serial_run,
  output var logic          serial_reverse,
  // Reference words.
  output var logic [FW-1:0] serial_ref,
  output var logic [FW-1:0] pot_ref,
  output var logic [FW-1:0] voltage_analog_input,
  output var logic [FW-1:0] dual_analog_input_ma,
  output var logic [FW-1:0] dual_analog_input_volt,
  output var logic [FW-1:0] updown_ref
);
  // Spaced levels keep every single source and every sum distinct.
  initial
  begin
    serial_ref = 16'hf;
    pot_ref = 16'h5;
    voltage_analog_input = 16'h7;
    dual_analog_input_ma = 16'h9;
    dual_analog_input_volt = 16'hb;
    updown_ref = 16'hd;
    multi_function_inputs = 5'h00;
    {forward_run_input, reverse_run_input, key_run, key_stop, serial_run, serial_reverse} = 6'h00;
  end

  // All levels move together by non-blocking assignment at the next rising edge.
  task automatic pins(input logic [4:0] m, input logic [5:0] v);
    @(posedge pclk);
    multi_function_inputs <= m;
    {forward_run_input, reverse_run_input, key_run, key_stop, serial_run, serial_reverse} <= v;
  endtask
endmodule // drive_terminals
`default_nettype wire

/* File: sim/dual_source_select_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_source_select_chk #(
  parameter int FW = 16
) (
  // Clock and reset.
  input wire logic          pclk,
  input wire logic          presetn,
  // Register bus.
  input wire logic          ce,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // Selection and drive.
  input wire logic [4:0]    multi_function_inputs,
  input wire logic [FW-1:0] out_freq_q,
  input wire logic          out_reverse_q,
  input wire logic          running_q,
  input wire logic          alt_set_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && !penable && ce ##1 psel && penable;
  endsequence

  a_ready_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  a_alt_sync: assert property ($rose(alt_set_q) |-> |$past(multi_function_inputs, 3))
    else $error("alternate set rose too early");
  a_ramp_step: assert property ($changed(out_freq_q) |->
    out_freq_q == $past(out_freq_q) + 1'b1 || out_freq_q == $past(out_freq_q) - 1'b1)
    else $error("output frequency jumped");
  a_flip_at_zero: assert property ($changed(out_reverse_q) |-> $past(out_freq_q) == '0)
    else $error("direction flipped while turning");
  a_run_flag: assert property (out_freq_q != '0 |-> running_q)
    else $error("output live while stopped");
  a_ro_write: assert property (psel && penable && pwrite && paddr inside {8'h34, 8'h38} |-> pslverr)
    else $error("read-only write accepted");
  a_unmapped_read: assert property (psel && penable && !pwrite && paddr > 8'h38 |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
  a_read_stands: assert property (s_access |=> $stable(prdata) && !pslverr)
    else $error("read data moved after access");
endmodule // dual_source_select_chk
`default_nettype wire

/* File: sim/dual_source_select_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module dual_source_select_tb_top;
  localparam int FW = 16;
  logic          pclk, presetn, ce, psel, penable, pwrite, re;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, rq;
  int            error_cnt = 0, tests_run = 0;
  wire           pready, pslverr, forward_run_input, reverse_run_input, key_run, key_stop, serial_run;
  wire           serial_reverse, out_reverse_q, running_q, alt_set_q;
  wire  [4:0]    multi_function_inputs;
  wire  [31:0]   prdata;
  wire  [FW-1:0] serial_ref, pot_ref, voltage_analog_input, dual_analog_input_ma, dual_analog_input_volt;
  wire  [FW-1:0] updown_ref, out_freq_q;

  dual_source_select #(.FW(FW)) uut (.*);
  drive_terminals #(.FW(FW)) far (.*);

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic t_reset_values();
    logic [31:0] exp [12];
    exp = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h10, 32'h10, 32'h0};
    for (int i = 0; i < 12; i++)
    begin
      rd(8'(i * 4));
      `CK(rq, exp[i])
    end
    rd(8'h34);
    `CK(rq[12:0], 13'h0010)
    rd(8'h3c);
    `CK(re, 1'b1)
  endtask

  task automatic t_refused();
    wr(8'h0c, 32'hb);
    `CK(re, 1'b1)
    wr(8'h10, 32'h1c);
    `CK(re, 1'b1)
    wr(8'h38, 32'h0);
    `CK(re, 1'b1)
    rd(8'h0c);
    `CK(rq, 32'h0)
  endtask

  task automatic t_freq_sources();
    logic [FW-1:0] exp [11];
    exp = '{16'h3, 16'h4, 16'h5, 16'h7, 16'h9, 16'hb, 16'he, 16'h10, 16'hc, 16'hf, 16'hd};
    wr(8'h24, 32'h1);
    wr(8'h28, 32'h1);
    wr(8'h2c, 32'h3);
    wr(8'h30, 32'h4);
    far.pins(5'h00, 6'b100000);
    for (int v = 0; v < 11; v++)
    begin
      wr(8'h04, 32'(v));
      cyc(40);
      `CK(out_freq_q, exp[v])
      rd(8'h34);
      `CK(rq[11:8], 4'(v))
    end
  endtask

  task automatic t_cmd_modes();
    far.pins(5'h00, 6'b010000);
    cyc(40);
    `CK({running_q, out_reverse_q}, 2'b11)
    wr(8'h00, 32'h2);
    far.pins(5'h00, 6'b100000);
    cyc(40);
    `CK({running_q, out_reverse_q}, 2'b10)
    far.pins(5'h00, 6'b110000);
    cyc(40);
    `CK({running_q, out_reverse_q}, 2'b11)
    wr(8'h00, 32'h0);
    far.pins(5'h00, 6'b001000);
    cyc(4);
    far.pins(5'h00, 6'b000000);
    cyc(40);
    `CK({running_q, out_reverse_q}, 2'b10)
    far.pins(5'h00, 6'b000100);
    cyc(4);
    far.pins(5'h00, 6'b000000);
    cyc(40);
    `CK({running_q, out_freq_q}, {1'b0, 16'h0})
    wr(8'h00, 32'h3);
    far.pins(5'h00, 6'b000011);
    cyc(40);
    `CK({running_q, out_reverse_q}, 2'b11)
  endtask

  task automatic t_alt_switch();
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h3);
    wr(8'h20, 32'h16);
    far.pins(5'h01, 6'b100010);
    cyc(40);
    `CK(alt_set_q, 1'b0)
    far.pins(5'h11, 6'b100010);
    cyc(2);
    `CK(alt_set_q, 1'b0)
    cyc(1);
    `CK(alt_set_q, 1'b1)
    repeat (30)
    begin
      cyc(1);
      `CK(running_q, 1'b1)
    end
    `CK(out_freq_q, 16'h7)
    rd(8'h34);
    `CK({rq[11:8], rq[5:4]}, 6'h0d)
    far.pins(5'h01, 6'b100000);
    cyc(40);
    `CK({alt_set_q, running_q, out_freq_q}, {2'b00, 16'h0})
    far.pins(5'h01, 6'b000010);
    cyc(40);
    `CK(out_freq_q, 16'hd)
    far.pins(5'h11, 6'b000010);
    cyc(40);
    `CK({alt_set_q, running_q, out_freq_q}, {2'b10, 16'h0})
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_refused();
    t_freq_sources();
    t_cmd_modes();
    t_alt_switch();
    wrap_up();
  end
endmodule // dual_source_select_tb_top

bind dual_source_select dual_source_select_chk #(.FW(FW)) chk (.*);
`default_nettype wire
